// >>> hdl/pog_regs.svh
// register offsets, field limits and timing constants of the output gating block
`ifndef POG_REGS_SVH
`define POG_REGS_SVH

// register byte offsets (low address byte)
`define POG_R_CTRL    8'h00
`define POG_R_MODE    8'h04
`define POG_R_OCST    8'h08
`define POG_R_STAT    8'h0C
`define POG_R_CMD     8'h20
`define POG_R_PER     8'h40
`define POG_R_DITH    8'h60
`define POG_R_CUR     8'h80

// control register bits
`define POG_CTRL_APP  0
`define POG_CTRL_RED  1
`define POG_CTRL_GRN  2

// clock and tick rates
`define POG_CLK_HZ    20000000
`define POG_US_CYC    (`POG_CLK_HZ / 1000000)
`define POG_US_PER_MS 1000

// pwm period limits in microseconds
`define POG_PWM_FMIN_HZ 33
`define POG_PWM_FMAX_HZ 4000
`define POG_PER_MAX   (1000000 / `POG_PWM_FMIN_HZ)
`define POG_PER_MIN   (1000000 / `POG_PWM_FMAX_HZ)
`define POG_FIX_MASK  8'hC0
`define POG_FIX_PER   15'h03E8

// dither limits
`define POG_DITH_FMAX_HZ 250
`define POG_HALF_MIN  (1000 / (2 * `POG_DITH_FMAX_HZ))
`define POG_HALF_RST  8'h04
`define POG_DITH_AMP_MA 500

// current scale: command lsb 0.25 mA
`define POG_CMD_FS_MA 3000
`define POG_CMD_LSB_UA 250
`define POG_CMD_FULL  (`POG_CMD_FS_MA * 1000 / `POG_CMD_LSB_UA)
`define POG_AMP_MAX   (`POG_DITH_AMP_MA * 1000 / `POG_CMD_LSB_UA)
`define POG_OC_TRIP_MA 5000
`define POG_OC_TRIP   (`POG_OC_TRIP_MA * 1000 / `POG_CMD_LSB_UA)

// redundant switch hold-off in ms ticks, one extra for tick phase
`define POG_HOLD_TIME_MS 250
`define POG_HOLD_TICKS (`POG_HOLD_TIME_MS + 1)

// can variant: 1 gives two channels
`define POG_CAN_DUAL  1'b1

`endif

// >>> hdl/pog_pkg.sv
// shared types of the output gating block
package pog_pkg;
	typedef logic [13:0] pog_cmd_t;
	typedef logic [15:0] pog_cur_t;
	typedef logic [14:0] pog_per_t;
	typedef logic [10:0] pog_amp_t;
	typedef logic [7:0]  pog_half_t;
endpackage

// >>> hdl/pog_chan.sv
// one pwm channel: period counter, dither and closed loop cut-off
`timescale 1ns/1ps
`include "pog_regs.svh"
module pog_chan
(
	input  wire logic              clock,   // system clock
	input  wire logic              rst_b,   // async reset, low
	input  wire logic              us_tick, // 1 us enable
	input  wire logic              ms_tick, // 1 ms enable
	input  wire pog_pkg::pog_per_t per,     // period in us
	input  wire pog_pkg::pog_cmd_t cmd,     // command, 0.25 mA
	input  wire pog_pkg::pog_amp_t amp,     // dither amplitude
	input  wire pog_pkg::pog_half_t half,   // dither half period ms
	input  wire logic              closed,  // closed loop mode
	input  wire pog_pkg::pog_cur_t cur,     // measured current
	output logic                   pwm_q    // pwm drive
);
	import pog_pkg::*;

	typedef struct packed
	{
		logic [14:0] cnt;
		logic [7:0]  dcnt;
		logic        dsgn;
		logic        arm;
		logic        pwm;
	} pog_chs_t;

	pog_chs_t           s_q;
	pog_chs_t           s_d;
	logic signed [16:0] e_raw;
	pog_cmd_t           eff;
	logic [28:0]        lhs;
	logic [28:0]        rhs;
	logic               on;

	// period, dither and drive decision
	always_comb
	begin
		s_d = s_q;
		// period counter, restarts arm of each cycle [RQ1]
		if (us_tick)
		begin
			if (s_q.cnt >= per - 15'h0001)
			begin
				s_d.cnt = '0;
				s_d.arm = 1'b1;
			end
			else
				s_d.cnt = s_q.cnt + 15'h0001;
		end
		// dither square wave in ms steps [RQ2]
		if (ms_tick)
		begin
			if (s_q.dcnt >= half - 8'h01)
			begin
				s_d.dcnt = '0;
				s_d.dsgn = ~s_q.dsgn;
			end
			else
				s_d.dcnt = s_q.dcnt + 8'h01;
		end
		if (s_q.dsgn)
			e_raw = $signed({3'h0, cmd}) + $signed({6'h00, amp});
		else
			e_raw = $signed({3'h0, cmd}) - $signed({6'h00, amp});
		// effective command held inside full scale [RQ3]
		if (e_raw < 0)
			eff = '0;
		else if (e_raw > 17'(`POG_CMD_FULL))
			eff = 14'(`POG_CMD_FULL);
		else
			eff = e_raw[13:0];
		lhs = 29'(s_q.cnt) * 29'(`POG_CMD_FULL);
		rhs = 29'(per) * 29'(eff);
		// closed loop: on from period start until current reaches command
		if (closed)
		begin
			on = s_q.arm && (cur < {2'h0, eff});
			if (cur >= {2'h0, eff})
				s_d.arm = 1'b0;
		end
		else
			on = lhs < rhs;
		s_d.pwm = on && (eff != '0);
	end

	// state register
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign pwm_q = s_q.pwm;

	a_dith_step: assert property (@(posedge clock) disable iff (!rst_b)
		(s_q.dsgn != $past(s_q.dsgn)) |-> $past(ms_tick)) // [RQ2]
		else $error("dither changed without ms tick");
endmodule

// >>> hdl/pog_top.sv
// output gating block: pwm channels, over-current latch, redundant switch, leds, can routing
//
// Summary of operation
// RQ1: pwm period programmable from 33 Hz to 4000 Hz; some channels fixed.
// RQ2: optional dither in steps, up to 250 Hz and 0.5 A amplitude.
// RQ3: current command full scale 3000 mA in 0.25 mA steps.
// RQ4: driver latches off when instantaneous current passes the 5 A trip point.
// RQ5: latch-off applies in open loop mode as well.
// RQ6: tripped output stays off until software clears its latch.
// RQ7: closed loop latch clears only once the command has returned to zero.
// RQ8: high side is two series switches, secondary and primary owned.
// RQ9: secondary controller may open any redundant switch at any time.
// RQ10: opened redundant switch held off 250 ms before re-enable.
// RQ11: with redundant switch on, channel drives as primary commands.
// RQ12: secondary sees digital feedback of each redundant switch state.
// RQ13: primary can read current feedback of every channel.
// RQ14: red and green indicators driven by primary application software.
// RQ15: green lit and red dark before application software starts.
// RQ16: yellow colours signal failures; application software cannot drive them.
// RQ17: green-position yellow from primary, red-position yellow from secondary.
// RQ18: enabled yellow overrides the colour sharing its position.
// RQ19: large variant: one can channel primary only, one shared.
// RQ20: can ports are 2.0B with extended frames up to 1 Mbit/s.
// RQ21: hold-off timer starts at disable edge; enable requests ignored meanwhile.
// RQ22: each over-current latch readable as a flag cleared only by software.
//
// Added by the designer: the address map and register access over AHB-Lite.
`timescale 1ns/1ps
`include "pog_regs.svh"
module pog_top
#(
	parameter logic [9:0] US_PER_MS = 10'(`POG_US_PER_MS) // us ticks per ms tick
)
(
	input  wire logic              clock,         // system clock, 20 MHz
	input  wire logic              rst_b,         // async reset, low
	input  wire logic              hsel,          // ahb slave select
	input  wire logic [31:0]       haddr,         // ahb address
	input  wire logic [1:0]        htrans,        // ahb transfer type
	input  wire logic              hwrite,        // ahb write
	input  wire logic [2:0]        hsize,         // ahb size, words only
	input  wire logic [31:0]       hwdata,        // ahb write data
	input  wire logic              hready,        // ahb bus ready
	output logic [31:0]            hrdata,        // ahb read data
	output logic                   hreadyout,     // ahb slave ready
	output logic                   hresp,         // ahb response, okay
	input  wire logic [7:0][15:0]  cur_in,        // current samples, 0.25 mA
	input  wire logic [7:0]        sec_en_req,    // secondary: redundant enable
	input  wire logic              prim_yel_req,  // primary: yellow at green
	input  wire logic              sec_yel_req,   // secondary: yellow at red
	input  wire logic              can_a_rx,      // can a receive pin
	input  wire logic              can_b_rx,      // can b receive pin
	input  wire logic              prim_can_a_tx, // primary can a transmit
	input  wire logic              prim_can_b_tx, // primary can b transmit
	input  wire logic              sec_can_b_tx,  // secondary can b transmit
	output logic [7:0]             pwm_hs,        // primary high side switch
	output logic [7:0]             red_sw,        // redundant high side switch
	output logic [7:0]             red_fb,        // redundant switch feedback
	output logic                   led_red,       // red colour
	output logic                   led_grn,       // green colour
	output logic                   led_yel_g,     // yellow at green position
	output logic                   led_yel_r,     // yellow at red position
	output logic                   prim_can_a_rx, // can a to primary
	output logic                   prim_can_b_rx, // can b to primary
	output logic                   sec_can_b_rx,  // can b to secondary
	output logic                   can_a_tx,      // can a transmit pin
	output logic                   can_b_tx       // can b transmit pin
);
	import pog_pkg::*;

	typedef struct packed
	{
		logic [31:0]      rdata;
		logic             wpend;
		logic             wok;
		logic [7:0]       waddr;
		logic             app;
		logic             red;
		logic             grn;
		logic [7:0]       closed;
		logic [7:0]       digi;
		logic [7:0]       oc;
		logic [7:0][13:0] cmd;
		logic [7:0][14:0] per;
		logic [7:0][10:0] amp;
		logic [7:0][7:0]  half;
		logic [7:0][7:0]  hold;
		logic [7:0]       rsw;
		logic [7:0]       rfb;
		logic [7:0]       hs;
		logic             lr;
		logic             lg;
		logic             lyg;
		logic             lyr;
		logic             pca;
		logic             pcb;
		logic             scb;
		logic             cat;
		logic             cbt;
		logic [4:0]       usc;
		logic [9:0]       msc;
		logic             ust;
		logic             mst;
	} pog_st_t;

	localparam logic [7:0] FIX_CH = `POG_FIX_MASK; // fixed-frequency channels

	pog_st_t     st_q;
	pog_st_t     st_d;
	logic [7:0]  pwm;
	logic [7:0]  over;
	logic [7:0]  clr;
	logic [2:0]  ch;
	logic [2:0]  wch;
	logic [14:0] wper;
	logic [10:0] wamp;
	logic [7:0]  whalf;
	logic [13:0] wcmd;

	// register group hit: group bits 7:5 of the offset only, block base checked by the caller
	function automatic logic grp_hit(input logic [7:0] a, input logic [7:0] base);
		grp_hit = (a[7:5] == base[7:5]);
	endfunction

	// pwm channels
	for (genvar g = 0; g < 8; g++)
	begin : g_ch
		pog_chan u_ch
		(
			.clock   (clock),
			.rst_b   (rst_b),
			.us_tick (st_q.ust),
			.ms_tick (st_q.mst),
			.per     (st_q.per[g]),
			.cmd     (st_q.cmd[g]),
			.amp     (st_q.amp[g]),
			.half    (st_q.half[g]),
			.closed  (st_q.closed[g]),
			.cur     (cur_in[g]),
			.pwm_q   (pwm[g])
		);
	end

	// next state of the whole block
	always_comb
	begin
		st_d = st_q;
		ch = haddr[4:2];
		wch = st_q.waddr[4:2];
		clr = '0;
		wcmd = hwdata[13:0];
		wper = hwdata[14:0];
		wamp = hwdata[10:0];
		whalf = hwdata[23:16];
		// microsecond and millisecond enables
		st_d.ust = 1'b0;
		st_d.mst = 1'b0;
		if (st_q.usc >= 5'(`POG_US_CYC - 1))
		begin
			st_d.usc = '0;
			st_d.ust = 1'b1;
		end
		else
			st_d.usc = st_q.usc + 5'h01;
		if (st_q.ust)
		begin
			if (st_q.msc >= US_PER_MS - 10'h001)
			begin
				st_d.msc = '0;
				st_d.mst = 1'b1;
			end
			else
				st_d.msc = st_q.msc + 10'h001;
		end
		// ahb address phase: capture write, prepare read data
		st_d.wpend = 1'b0;
		if (hsel && hready && htrans[1])
		begin
			st_d.wpend = hwrite;
			st_d.wok = (haddr[31:8] == 24'h000000);
			st_d.waddr = haddr[7:0];
			st_d.rdata = '0;
			if (!hwrite && haddr[31:8] == 24'h000000)
			begin
				if (haddr[7:0] == `POG_R_CTRL)
					st_d.rdata = {29'h0, st_q.grn, st_q.red, st_q.app};
				else if (haddr[7:0] == `POG_R_MODE)
					st_d.rdata = {16'h0000, st_q.digi, st_q.closed};
				else if (haddr[7:0] == `POG_R_OCST)
					st_d.rdata = {24'h000000, st_q.oc}; // [RQ22]
				else if (haddr[7:0] == `POG_R_STAT)
					st_d.rdata = {16'h0000, st_q.hs, st_q.rfb};
				else if (grp_hit(haddr[7:0], `POG_R_CMD))
					st_d.rdata = {18'h00000, st_q.cmd[ch]};
				else if (grp_hit(haddr[7:0], `POG_R_PER))
					st_d.rdata = {17'h00000, st_q.per[ch]};
				else if (grp_hit(haddr[7:0], `POG_R_DITH))
					st_d.rdata = {8'h00, st_q.half[ch], 5'h00, st_q.amp[ch]};
				else if (grp_hit(haddr[7:0], `POG_R_CUR))
					st_d.rdata = {16'h0000, cur_in[ch]}; // [RQ13]
			end
		end
		// ahb data phase: apply write
		if (st_q.wpend && st_q.wok)
		begin
			if (st_q.waddr == `POG_R_CTRL)
			begin
				st_d.app = hwdata[`POG_CTRL_APP];
				st_d.red = hwdata[`POG_CTRL_RED]; // [RQ14]
				st_d.grn = hwdata[`POG_CTRL_GRN];
			end
			else if (st_q.waddr == `POG_R_MODE)
			begin
				st_d.closed = hwdata[7:0];
				st_d.digi = hwdata[15:8];
			end
			else if (st_q.waddr == `POG_R_OCST)
				clr = hwdata[7:0];
			else if (grp_hit(st_q.waddr, `POG_R_CMD))
			begin
				if (wcmd > 14'(`POG_CMD_FULL))
					wcmd = 14'(`POG_CMD_FULL);
				st_d.cmd[wch] = wcmd; // [RQ3]
			end
			else if (grp_hit(st_q.waddr, `POG_R_PER))
			begin
				// period held in range; fixed channels keep theirs [RQ1]
				if (wper < 15'(`POG_PER_MIN))
					wper = 15'(`POG_PER_MIN);
				else if (wper > 15'(`POG_PER_MAX))
					wper = 15'(`POG_PER_MAX);
				if (!FIX_CH[wch])
					st_d.per[wch] = wper;
			end
			else if (grp_hit(st_q.waddr, `POG_R_DITH))
			begin
				// dither amplitude and rate limits [RQ2]
				if (wamp > 11'(`POG_AMP_MAX))
					wamp = 11'(`POG_AMP_MAX);
				if (whalf < 8'(`POG_HALF_MIN))
					whalf = 8'(`POG_HALF_MIN);
				st_d.amp[wch] = wamp;
				st_d.half[wch] = whalf;
			end
		end
		for (int i = 0; i < 8; i++)
		begin
			// trip compare on raw sample, any mode [RQ4] [RQ5]
			over[i] = cur_in[i] > 16'(`POG_OC_TRIP);
			// closed loop latch kept while command nonzero [RQ7]
			if (st_q.closed[i] && st_q.cmd[i] != '0)
				clr[i] = 1'b0;
			// software clear, a new trip wins [RQ6] [RQ22]
			st_d.oc[i] = (st_q.oc[i] && !clr[i]) || over[i];
			// primary switch: pwm or digital level, off while latched [RQ11]
			if (st_q.digi[i])
				st_d.hs[i] = (st_q.cmd[i] != '0) && !st_d.oc[i];
			else
				st_d.hs[i] = pwm[i] && !st_d.oc[i];
			// redundant switch opened by secondary at any time [RQ9]
			if (st_q.rsw[i] && !sec_en_req[i])
			begin
				st_d.rsw[i] = 1'b0;
				st_d.hold[i] = 8'(`POG_HOLD_TICKS); // [RQ21]
			end
			else if (!st_q.rsw[i])
			begin
				// enable only once the hold-off has run out [RQ10] [RQ21]
				if (st_q.hold[i] != 8'h00)
				begin
					if (st_q.mst)
						st_d.hold[i] = st_q.hold[i] - 8'h01;
				end
				else if (sec_en_req[i])
					st_d.rsw[i] = 1'b1;
			end
		end
		// feedback of redundant switch state [RQ12]
		st_d.rfb = st_q.rsw;
		// indicators: green until app runs, yellows override [RQ15] [RQ17] [RQ18]
		st_d.lyg = prim_yel_req;
		st_d.lyr = sec_yel_req; // [RQ16]
		st_d.lg = !prim_yel_req && (st_q.app ? st_q.grn : 1'b1);
		st_d.lr = !sec_yel_req && st_q.app && st_q.red;
		// can routing: a to primary, b shared, wired-and transmit [RQ19] [RQ20]
		st_d.pca = `POG_CAN_DUAL ? can_a_rx : 1'b1;
		st_d.pcb = can_b_rx;
		st_d.scb = can_b_rx;
		st_d.cat = `POG_CAN_DUAL ? prim_can_a_tx : 1'b1;
		st_d.cbt = prim_can_b_tx && sec_can_b_tx;
	end

	// state register with reset values
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			st_q <= '0;
			st_q.per <= {8{`POG_FIX_PER}};
			st_q.half <= {8{`POG_HALF_RST}};
			st_q.lg <= 1'b1;
			st_q.pca <= 1'b1;
			st_q.pcb <= 1'b1;
			st_q.scb <= 1'b1;
			st_q.cat <= 1'b1;
			st_q.cbt <= 1'b1;
		end
		else
			st_q <= st_d;
	end

	// outputs straight from the state register
	assign hrdata = st_q.rdata;
	assign hreadyout = 1'b1 | st_q.wpend;
	assign hresp = 1'b0 & st_q.wpend;
	assign pwm_hs = st_q.hs; // [RQ8]
	assign red_sw = st_q.rsw; // [RQ8]
	assign red_fb = st_q.rfb;
	assign led_red = st_q.lr;
	assign led_grn = st_q.lg;
	assign led_yel_g = st_q.lyg;
	assign led_yel_r = st_q.lyr;
	assign prim_can_a_rx = st_q.pca;
	assign prim_can_b_rx = st_q.pcb;
	assign sec_can_b_rx = st_q.scb;
	assign can_a_tx = st_q.cat;
	assign can_b_tx = st_q.cbt;

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_b);

	a_oc_trip: assert property (over[0] |=> st_q.oc[0]) // [RQ4]
		else $error("over-current did not latch");
	a_oc_drive: assert property (over[0] |=> !st_q.hs[0]) // [RQ5]
		else $error("switch on after trip");
	a_oc_stays: assert property ((st_q.oc[0] && !over[0] && !(st_q.wpend
		&& st_q.waddr == `POG_R_OCST)) |=> st_q.oc[0]) // [RQ6]
		else $error("latch cleared without software");
	a_oc_closed_hold: assert property ((st_q.oc[0] && st_q.closed[0]
		&& st_q.cmd[0] != 14'h0000) |=> st_q.oc[0]) // [RQ7]
		else $error("closed loop latch cleared with command");
	// hold-off checks on channel 3, the one that the secondary drops
	a_hold_min: assert property ($fell(st_q.rsw[3]) |=> !st_q.rsw[3] [*8]) // [RQ10]
		else $error("redundant switch re-enabled early");
	a_hold_gate: assert property ($rose(st_q.rsw[3]) |-> $past(st_q.hold[3]) == 8'h00) // [RQ21]
		else $error("enable taken during hold-off");
	a_red_enable: assert property ((st_q.hold[0] == 8'h00 && !st_q.rsw[0]
		&& sec_en_req[0]) |=> st_q.rsw[0]) // [RQ11]
		else $error("enable request not taken");
	a_fb_track: assert property (st_q.rsw[1] |=> st_q.rfb[1]) // [RQ12]
		else $error("feedback does not follow switch");
	a_led_boot: assert property ((!st_q.app && !prim_yel_req && !sec_yel_req)
		|=> (st_q.lg && !st_q.lr)) // [RQ15]
		else $error("boot indicator wrong");
	a_yel_prio: assert property (prim_yel_req |=> (st_q.lyg && !st_q.lg)) // [RQ18]
		else $error("yellow does not override green");
endmodule

// >>> tb/pog_load.sv
// solenoid load model seen behind the two series high side switches
`timescale 1ns/1ps
module pog_load
(
	input  wire logic             clock,   // system clock
	input  wire logic [7:0]       pwm_hs,  // primary switch drive
	input  wire logic [7:0]       red_sw,  // redundant switch drive
	input  wire logic [7:0]       short_c, // bench-commanded short per channel
	output logic      [7:0][15:0] cur      // sampled coil current
);
	// current only with both switches closed; a short pulls 5.12 A
	always_ff @(posedge clock)
	begin
		for (int i = 0; i < 8; i++)
			cur[i] <= (pwm_hs[i] & red_sw[i]) ? (short_c[i] ? 16'h5000 : 16'h0FA0) : 16'h0000;
	end
endmodule

// >>> tb/pog_top_tb.sv
// self-checking bench of the output gating block
`timescale 1ns/1ps
module pog_top_tb;
	localparam logic [9:0] US_MS = 10'h002; // 40 clocks per ms tick
	logic             clock = 1'b0;
	logic             rst_b = 1'b0;
	logic             hsel = 1'b0;
	logic             hwrite = 1'b0;
	logic [31:0]      haddr = 32'h0;
	logic [1:0]       htrans = 2'h0;
	logic [2:0]       hsize = 3'h2;
	logic [31:0]      hwdata = 32'h0;
	logic [31:0]      hrdata;
	logic             hreadyout, hresp;
	logic [7:0][15:0] cur_in;
	logic [7:0]       sec_en_req = 8'h0F;
	logic [7:0]       short_c = 8'h00;
	logic             prim_yel_req = 1'b0;
	logic             sec_yel_req = 1'b0;
	logic             can_a_rx = 1'b1;
	logic             can_b_rx = 1'b1;
	logic             prim_can_a_tx = 1'b1;
	logic             prim_can_b_tx = 1'b1;
	logic             sec_can_b_tx = 1'b1;
	logic [7:0]       pwm_hs, red_sw, red_fb;
	logic             led_red, led_grn, led_yel_g, led_yel_r;
	logic             prim_can_a_rx, prim_can_b_rx, sec_can_b_rx, can_a_tx, can_b_tx;
	int               num_errors = 0;
	int               check_count = 0;
	int               cyc = 0;

	pog_top #(.US_PER_MS(US_MS)) uut (.clock(clock), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .cur_in(cur_in), .sec_en_req(sec_en_req),
		.prim_yel_req(prim_yel_req), .sec_yel_req(sec_yel_req), .can_a_rx(can_a_rx), .can_b_rx(can_b_rx),
		.prim_can_a_tx(prim_can_a_tx), .prim_can_b_tx(prim_can_b_tx), .sec_can_b_tx(sec_can_b_tx),
		.pwm_hs(pwm_hs), .red_sw(red_sw), .red_fb(red_fb), .led_red(led_red), .led_grn(led_grn),
		.led_yel_g(led_yel_g), .led_yel_r(led_yel_r), .prim_can_a_rx(prim_can_a_rx),
		.prim_can_b_rx(prim_can_b_rx), .sec_can_b_rx(sec_can_b_rx), .can_a_tx(can_a_tx), .can_b_tx(can_b_tx));
	pog_load load (.clock(clock), .pwm_hs(pwm_hs), .red_sw(red_sw), .short_c(short_c), .cur(cur_in));

	// 20 MHz clock
	always #25 clock = ~clock;

	// hang guard
	always @(posedge clock)
	begin
		cyc++;
		if (cyc == 40000)
		begin
			num_errors++;
			print_verdict();
		end
	end

	task print_verdict();
		$display("checks %0d mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// one single-word ahb transfer, held until hready is seen
	task ahb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
		@(posedge clock);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge clock); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clock); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] v;
		ahb(1'b1, a, d, v);
	endtask

	task rdc(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] v;
		ahb(1'b0, a, 32'h0, v);
		chk(v, exp);
	endtask

	// poll the latch flags until the masked ones are set
	task wait_oc(input logic [31:0] m);
		logic [31:0] v;
		int n;
		v = 32'h0;
		n = 0;
		while ((v & m) !== m && n < 4000)
		begin
			ahb(1'b0, 8'h08, 32'h0, v);
			n++;
		end
		chk(v & m, m);
	endtask

	task t_reset();
		chk({hresp, hreadyout, led_grn, led_red, led_yel_g, led_yel_r}, 32'h18);
		rdc(8'h00, 32'h0);
		rdc(8'h40, 32'h3E8);
		rdc(8'h60, 32'h40000);
		wr(8'hF0, 32'hFFFF);
		rdc(8'hF0, 32'h0);
		$display("reset test done");
	endtask

	task t_leds();
		wr(8'h00, 32'hFFFFFFF9);
		repeat (2) @(posedge clock);
		chk({led_grn, led_red, led_yel_g, led_yel_r}, 32'h0);
		wr(8'h00, 32'h7);
		prim_yel_req <= 1'b1;
		sec_yel_req <= 1'b1;
		repeat (2) @(posedge clock);
		chk({led_grn, led_red, led_yel_g, led_yel_r}, 32'h3);
		prim_yel_req <= 1'b0;
		sec_yel_req <= 1'b0;
		repeat (2) @(posedge clock);
		chk({led_grn, led_red, led_yel_g, led_yel_r}, 32'hC);
		$display("led test done");
	endtask

	task t_limits();
		wr(8'h40, 32'h14);
		rdc(8'h40, 32'hFA);
		wr(8'h40, 32'h7FFF);
		rdc(8'h40, 32'h765F);
		wr(8'h58, 32'h1F4);
		rdc(8'h58, 32'h3E8);
		wr(8'h24, 32'h3FFF);
		rdc(8'h24, 32'h2EE0);
		wr(8'h64, 32'h107FF);
		rdc(8'h64, 32'h207D0);
		wr(8'h44, 32'hFA);
		$display("limit test done");
	endtask

	task t_trip();
		wr(8'h20, 32'h2EE0);
		repeat (5) @(posedge clock);
		rdc(8'h80, 32'hFA0);
		short_c <= 8'h01;
		wait_oc(32'h1);
		chk(pwm_hs[0], 1'b0);
		repeat (50) @(posedge clock);
		chk(pwm_hs[0], 1'b0);
		rdc(8'h08, 32'h1);
		short_c <= 8'h00;
		wr(8'h08, 32'h1);
		rdc(8'h08, 32'h0);
		repeat (5) @(posedge clock);
		chk(pwm_hs[0], 1'b1);
		wr(8'h04, 32'h2);
		short_c <= 8'h02;
		wait_oc(32'h2);
		short_c <= 8'h00;
		wr(8'h08, 32'h2);
		rdc(8'h08, 32'h2);
		wr(8'h24, 32'h0);
		wr(8'h08, 32'h2);
		rdc(8'h08, 32'h0);
		$display("trip test done");
	endtask

	task t_redund();
		int t0;
		wr(8'h2C, 32'h2EE0);
		repeat (5) @(posedge clock);
		rdc(8'h0C, 32'h90F);
		rdc(8'h8C, 32'hFA0);
		sec_en_req <= 8'h07;
		@(posedge clock);
		sec_en_req <= 8'h0F;
		t0 = cyc;
		repeat (3) @(posedge clock);
		chk({red_sw[3], red_fb[3]}, 32'h0);
		rdc(8'h8C, 32'h0);
		while (red_sw[3] !== 1'b1 && cyc - t0 < 12000)
			@(posedge clock);
		chk(cyc - t0 >= 10000 && cyc - t0 <= 10050, 32'h1);
		repeat (3) @(posedge clock);
		chk(red_fb[3], 1'b1);
		rdc(8'h8C, 32'hFA0);
		// digital mode on channel 2: level follows command, not pwm
		wr(8'h04, 32'h400);
		wr(8'h28, 32'h1);
		repeat (3) @(posedge clock);
		chk(pwm_hs[2], 1'b1);
		wr(8'h28, 32'h0);
		repeat (3) @(posedge clock);
		chk(pwm_hs[2], 1'b0);
		$display("redundant test done");
	endtask

	task t_can();
		can_a_rx <= 1'b0;
		can_b_rx <= 1'b0;
		prim_can_a_tx <= 1'b0;
		sec_can_b_tx <= 1'b0;
		repeat (3) @(posedge clock);
		chk({prim_can_a_rx, prim_can_b_rx, sec_can_b_rx, can_a_tx, can_b_tx}, 32'h0);
		can_a_rx <= 1'b1;
		can_b_rx <= 1'b1;
		prim_can_a_tx <= 1'b1;
		sec_can_b_tx <= 1'b1;
		prim_can_b_tx <= 1'b0;
		repeat (3) @(posedge clock);
		chk({prim_can_a_rx, prim_can_b_rx, sec_can_b_rx, can_a_tx, can_b_tx}, 32'h1E);
		$display("can test done");
	endtask

	// main sequence
	initial
	begin
		repeat (4) @(posedge clock);
		rst_b <= 1'b1;
		@(posedge clock);
		t_reset();
		t_leds();
		t_limits();
		t_trip();
		t_redund();
		t_can();
		print_verdict();
	end
endmodule
